/* hdl/period_timer.sv */
// Eight-bit period timer with prescaler, postscaler and register port
//
// What this block does
// - Count up from zero, wrap after period match
// - Instruction tick prescaled by 1, 4 or 16
// - Period register read/write, resets to all ones
// - Count register read/write, cleared by reset
// - Postscaler ratio select plus one sets flag
// - Flag bit 1 flags, enable bit 1 enables
// - Control bit 2 runs or stops counting
// - Count/control writes and reset clear scalers
// - Control write keeps the count value
// - Pre-postscaler match drives serial port tick
// - Count and match form the PWM base
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module period_timer (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Avalon-MM register slave
    input wire logic [timer_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Interrupt request
    output logic irq,
    // Synchronous serial port shift clock source
    output logic sync_serial_tick,
    // PWM time base for the capture/compare units
    output logic [7:0] pwm_base_count,
    output logic pwm_base_match
);
    import timer_pkg::*;

    // ************************************************************
    // State
    // ************************************************************

    // Everything the timer remembers
    typedef struct packed {
        logic [1:0] quarter;  // Oscillator divide by four
        logic [7:0] count;    // Timer count
        logic [6:0] ctrl;     // Postscale, run, prescale
        logic [7:0] period;   // Period value
        logic flag;           // Sticky period interrupt flag
        logic enable;         // Period interrupt enable
        logic match;          // One-cycle period match pulse
        logic resp;           // Bus answer cycle
        logic [31:0] rdata;   // Read data held for the answer
    } timer_state_t;

    // State after reset
    localparam timer_state_t S_RST = '{
        quarter: 2'h0,
        count: COUNT_RST,
        ctrl: CTRL_RST,
        period: PERIOD_RST,
        flag: 1'b0,
        enable: 1'b0,
        match: 1'b0,
        resp: 1'b0,
        rdata: 32'h0000_0000
    };

    timer_state_t s_q; // Registered state
    timer_state_t s_d; // Next state

    // ************************************************************
    // Bus decode
    // ************************************************************

    logic req;        // Request present
    logic accept;     // Request completes at this edge
    logic wr_ok;      // Accepted write with low lane on
    logic wr_count;   // Write to the count register
    logic wr_ctrl;    // Write to the control register
    logic wr_period;  // Write to the period register
    logic wr_flags;   // Write to the flag register
    logic wr_enables; // Write to the enable register
    logic rd_flags;   // Accepted read of the flag register
    logic [7:0] wbyte; // Low byte of write data
    logic [31:0] rmux; // Read data selected by address

    assign req = avs_read || avs_write;
    assign accept = req && s_q.resp;
    assign wr_ok = accept && avs_write && avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];
    assign wr_count = wr_ok && reg_hit(avs_address, IDX_COUNT);
    assign wr_ctrl = wr_ok && reg_hit(avs_address, IDX_CTRL);
    assign wr_period = wr_ok && reg_hit(avs_address, IDX_PERIOD);
    assign wr_flags = wr_ok && reg_hit(avs_address, IDX_FLAGS);
    assign wr_enables = wr_ok && reg_hit(avs_address, IDX_ENABLES);
    assign rd_flags = accept && avs_read
        && reg_hit(avs_address, IDX_FLAGS);

    // Read multiplexer, unmapped addresses read zero
    always_comb begin
        rmux = 32'h0000_0000;
        if (reg_hit(avs_address, IDX_COUNT)) begin
            rmux[7:0] = s_q.count;
        end else if (reg_hit(avs_address, IDX_CTRL)) begin
            // Top bit is unimplemented and reads zero
            rmux[7:0] = {1'b0, s_q.ctrl};
        end else if (reg_hit(avs_address, IDX_PERIOD)) begin
            rmux[7:0] = s_q.period;
        end else if (reg_hit(avs_address, IDX_FLAGS)) begin
            rmux[FLAG_BIT] = s_q.flag;
        end else if (reg_hit(avs_address, IDX_ENABLES)) begin
            rmux[FLAG_BIT] = s_q.enable;
        end
    end

    // ************************************************************
    // Control fields
    // ************************************************************

    logic run;             // Timer running
    logic [1:0] presc_sel; // Prescale select
    logic [3:0] post_sel;  // Postscale select

    assign run = s_q.ctrl[RUN_BIT];
    assign presc_sel = s_q.ctrl[PRESC_LSB +: 2];
    assign post_sel = s_q.ctrl[POST_LSB +: 4];

    // Prescaler last count for a select value
    function automatic logic [3:0] presc_last(input logic [1:0] sel);
        case (sel)
            2'h0: presc_last = PRESC_LAST_1;
            2'h1: presc_last = PRESC_LAST_4;
            default: presc_last = PRESC_LAST_16;
        endcase
    endfunction : presc_last

    // ************************************************************
    // Scalers
    // ************************************************************

    scaler_if psc (); // Prescaler link
    scaler_if pst (); // Postscaler link

    logic inst_tick;  // Instruction clock, one cycle in four
    logic scl_clear;  // Clear both scaler counters
    logic cnt_tick;   // Timer count advances
    logic match_now;  // Count equals period on an advance

    assign inst_tick = (s_q.quarter == QUARTER_LAST);
    // Writes to count or control clear the scalers
    assign scl_clear = wr_count || wr_ctrl;

    // Prescaler fed by the instruction tick while running
    assign psc.tick = inst_tick && run;
    assign psc.clear = scl_clear;
    assign psc.limit = presc_last(presc_sel);

    // Timer advances on each prescaler wrap
    assign cnt_tick = psc.wrap;
    assign match_now = cnt_tick && !wr_count
        && (s_q.count == s_q.period);

    // Postscaler counts period matches, ratio select plus one
    assign pst.tick = match_now;
    assign pst.clear = scl_clear;
    assign pst.limit = post_sel;

    // Prescaler counter
    ratio_scaler u_presc (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .sc(psc)
    );

    // Postscaler counter
    ratio_scaler u_post (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .sc(pst)
    );

    // ************************************************************
    // Flag handling
    // ************************************************************

    logic flag_set; // Postscaler completes a ratio
    logic flag_clr; // Software clears the flag

    assign flag_set = pst.wrap;
    // A read clears only what it reported; a write of zero clears
    assign flag_clr = (rd_flags && s_q.rdata[FLAG_BIT])
        || (wr_flags && !wbyte[FLAG_BIT]);

    // ************************************************************
    // Next state
    // ************************************************************

    always_comb begin
        s_d = s_q;

        // Oscillator divided by four
        s_d.quarter = s_q.quarter + 2'h1;

        // Answer one cycle after the request appears
        s_d.resp = req && !s_q.resp;
        if (req && !s_q.resp) begin
            // Capture read data for the answer cycle
            s_d.rdata = rmux;
        end

        // Timer count
        if (wr_count) begin
            // Software load
            s_d.count = wbyte;
        end else if (match_now) begin
            // Matched the period, wrap to zero
            s_d.count = COUNT_RST;
        end else if (cnt_tick) begin
            // Normal advance
            s_d.count = s_q.count + 8'h01;
        end

        // Control register, count untouched
        if (wr_ctrl) begin
            s_d.ctrl = wbyte[6:0];
        end

        // Period register
        if (wr_period) begin
            s_d.period = wbyte;
        end

        // Interrupt enable
        if (wr_enables) begin
            s_d.enable = wbyte[FLAG_BIT];
        end

        // Sticky flag, a set in the same cycle wins
        if (wr_flags && wbyte[FLAG_BIT]) begin
            s_d.flag = 1'b1;
        end else if (flag_clr) begin
            s_d.flag = 1'b0;
        end
        if (flag_set) begin
            s_d.flag = 1'b1;
        end

        // Match pulse before the postscaler
        s_d.match = match_now;
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            // Reset clears count and scalers, period all ones
            s_q <= S_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************

    // Hold the master until the answer cycle
    assign avs_waitrequest = req && !s_q.resp;
    assign avs_readdata = s_q.rdata;
    // Level interrupt while flag and enable are both set
    assign irq = s_q.flag && s_q.enable;
    // Serial port shift clock source
    assign sync_serial_tick = s_q.match;
    // PWM time base
    assign pwm_base_count = s_q.count;
    assign pwm_base_match = s_q.match;

    // ************************************************************
    // Assertions
    // ************************************************************

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    logic div1_quiet; // Running at 1:1 with no scaler clear
    assign div1_quiet = run && (presc_sel == 2'h0) && !scl_clear;

    // Tick while steady at 1:1
    sequence s_div1_tick;
        cnt_tick && div1_quiet;
    endsequence

    // Four steady cycles after it
    sequence s_div1_hold;
        div1_quiet [*4];
    endsequence

    a_count_wrap: assert property (
        match_now |=> (s_q.count == 8'h00))
        else $error("count did not wrap after period match");

    a_count_step: assert property (
        cnt_tick && !wr_count && (s_q.count != s_q.period)
        |=> (s_q.count == $past(s_q.count) + 8'h01))
        else $error("count did not advance by one");

    a_presc_div1: assert property (
        s_div1_tick ##1 s_div1_hold |-> cnt_tick
        && !$past(cnt_tick) && !$past(cnt_tick, 2)
        && !$past(cnt_tick, 3))
        else $error("divide by one did not tick every four");

    // Reset checks opt out of the default disable, which would mute them
    a_period_reset: assert property (disable iff (1'b0)
        sys_rst |=> (s_q.period == PERIOD_RST))
        else $error("period not all ones after reset");

    a_count_reset: assert property (disable iff (1'b0)
        sys_rst |=> (s_q.count == COUNT_RST) && (psc.count == 4'h0)
        && (pst.count == 4'h0))
        else $error("count or scalers not cleared by reset");

    a_flag_set: assert property (
        pst.wrap |=> s_q.flag)
        else $error("postscaler wrap did not set the flag");

    a_flag_read: assert property (
        rd_flags |-> (avs_readdata[FLAG_BIT] == $past(s_q.flag)))
        else $error("flag bit read back wrong");

    a_stop_hold: assert property (
        !run && !wr_count |=> $stable(s_q.count))
        else $error("count moved while stopped");

    a_scaler_clear: assert property (
        scl_clear |=> (psc.count == 4'h0) && (pst.count == 4'h0))
        else $error("scalers not cleared by a write");

    a_ctrl_keeps: assert property (
        wr_ctrl |=> $stable(s_q.count))
        else $error("control write changed the count");

    a_match_out: assert property (
        match_now |=> sync_serial_tick ##1 !sync_serial_tick)
        else $error("serial tick is not a one-cycle match pulse");

    a_flag_sticky: assert property (
        s_q.flag && !flag_clr |=> s_q.flag)
        else $error("flag dropped without a clear");

    a_irq_raise: assert property (
        flag_set && s_q.enable && !wr_enables |=> irq)
        else $error("interrupt not raised for enabled flag");

endmodule : period_timer
`default_nettype wire

/* hdl/timer_pkg.sv */
// Constants shared by the period timer and its scaler counters
package timer_pkg;

    // ************************************************************
    // Register map: word index, byte address is index times four
    // ************************************************************
    localparam int unsigned ADDR_W = 10;
    localparam logic [7:0] IDX_FLAGS = 8'h0C;
    localparam logic [7:0] IDX_COUNT = 8'h11;
    localparam logic [7:0] IDX_CTRL = 8'h12;
    localparam logic [7:0] IDX_ENABLES = 8'h8C;
    localparam logic [7:0] IDX_PERIOD = 8'h92;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int unsigned FLAG_BIT = 1;
    localparam int unsigned RUN_BIT = 2;
    localparam int unsigned PRESC_LSB = 0;
    localparam int unsigned POST_LSB = 3;

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam logic [7:0] PERIOD_RST = 8'hFF;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [6:0] CTRL_RST = 7'h00;

    // ************************************************************
    // Cycle counts
    // ************************************************************
    localparam logic [1:0] QUARTER_LAST = 2'h3;
    localparam logic [3:0] PRESC_LAST_1 = 4'h0;
    localparam logic [3:0] PRESC_LAST_4 = 4'h3;
    localparam logic [3:0] PRESC_LAST_16 = 4'hF;

    // True when a byte address selects the register of this index
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [7:0] idx);
        reg_hit = (addr == {idx, 2'b00});
    endfunction : reg_hit

endpackage : timer_pkg

/* hdl/scaler_if.sv */
// Signals between the timer and one of its scaler counters
`timescale 1ns/10ps
`default_nettype none
interface scaler_if;
    logic tick;        // Advance by one
    logic clear;       // Return to zero, wins over tick
    logic [3:0] limit; // Last count before wrapping
    logic wrap;        // Tick that completes one ratio
    logic [3:0] count; // Present count
    modport counter (input tick, clear, limit, output wrap, count);
    modport owner (output tick, clear, limit, input wrap, count);
endinterface : scaler_if
`default_nettype wire

/* hdl/ratio_scaler.sv */
// Four-bit ratio counter used as prescaler and as postscaler
`timescale 1ns/10ps
`default_nettype none
module ratio_scaler (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Counter side of the scaler link
    scaler_if.counter sc
);
    import timer_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [3:0] cnt; // Ticks seen in this ratio
    } scaler_state_t;

    scaler_state_t s_q; // Registered state
    scaler_state_t s_d; // Next state

    // Wrap only on a tick that is not being cleared
    assign sc.wrap = sc.tick && !sc.clear && (s_q.cnt == sc.limit);
    assign sc.count = s_q.cnt;

    // Next state
    always_comb begin
        s_d = s_q;
        if (sc.clear) begin
            // Clear wins over any tick
            s_d.cnt = 4'h0;
        end else if (sc.wrap) begin
            // Ratio complete
            s_d.cnt = 4'h0;
        end else if (sc.tick) begin
            // Count one more input tick
            s_d.cnt = s_q.cnt + 4'h1;
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : ratio_scaler
`default_nettype wire

/* tb/tb_period_timer.sv */
// Self-checking testbench for the period timer
`timescale 1ns/10ps
`default_nettype none
module tb_period_timer;
    import timer_pkg::*;

    // ************************************************************
    // Signals, register addresses and the table of cases
    // ************************************************************
    localparam logic [9:0] A_FLG = {IDX_FLAGS, 2'b00};
    localparam logic [9:0] A_CNT = {IDX_COUNT, 2'b00};
    localparam logic [9:0] A_CTL = {IDX_CTRL, 2'b00};
    localparam logic [9:0] A_ENA = {IDX_ENABLES, 2'b00};
    localparam logic [9:0] A_PER = {IDX_PERIOD, 2'b00};
    localparam logic [9:0] A_BAD = 10'h04C; // Unmapped word
    // One bus case: address, write, byte enables, data, read-back
    typedef struct packed {
        logic [9:0] a;
        logic w;
        logic [3:0] be;
        logic [7:0] d;
        logic [7:0] e;
    } row_t;
    localparam row_t ROWS [13] = '{
        '{A_FLG, 1'b0, 4'hF, 8'h00, 8'h00},
        '{A_CNT, 1'b0, 4'hF, 8'h00, 8'h00},
        '{A_CTL, 1'b0, 4'hF, 8'h00, 8'h00},
        '{A_ENA, 1'b0, 4'hF, 8'h00, 8'h00},
        '{A_PER, 1'b0, 4'hF, 8'h00, 8'hFF},
        '{A_PER, 1'b1, 4'hF, 8'h5A, 8'h5A},
        '{A_PER, 1'b1, 4'h0, 8'h11, 8'h5A},
        '{A_CNT, 1'b1, 4'hF, 8'h33, 8'h33},
        '{A_CTL, 1'b1, 4'hF, 8'hFB, 8'h7B},
        '{A_ENA, 1'b1, 4'hF, 8'hFF, 8'h02},
        '{A_ENA, 1'b1, 4'hF, 8'h00, 8'h00},
        '{A_BAD, 1'b1, 4'hF, 8'hFF, 8'h00},
        '{A_CTL, 1'b1, 4'hF, 8'h00, 8'h00}
    };
    logic ref_clk;
    logic sys_rst;
    logic [9:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic irq;
    logic sync_serial_tick;
    logic [7:0] pwm_base_count;
    logic pwm_base_match;
    int num_errors; // Mismatches seen
    int n_compared; // Comparisons made
    logic [7:0] rd; // Last value read
    logic [7:0] tp; // Highest count seen
    int n; // Cycles or matches counted
    int m; // Postscale setting
    int k; // Loop index

    period_timer dut (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .irq(irq),
        .sync_serial_tick(sync_serial_tick),
        .pwm_base_count(pwm_base_count),
        .pwm_base_match(pwm_base_match)
    );

    // 100 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ************************************************************
    // Reporting, bus cycles and waits
    // ************************************************************
    task give_verdict();
        if (num_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    task automatic chk_reg(input string nm, input logic [7:0] e,
                           input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_reg

    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit

    task automatic chk_num(input string nm, input int e, input int g);
        n_compared++;
        if (g != e) begin
            num_errors++;
            $display("FAIL %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chk_num

    // A wait ran out of cycles: counted and the run ends
    task timed_out();
        num_errors++;
        $display("FAIL wait expected answer seen timeout");
        give_verdict();
    endtask : timed_out

    // One Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic [9:0] a, input logic w,
                       input logic [3:0] be, input logic [7:0] d);
        int t;
        t = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_byteenable <= be;
        avs_writedata <= {24'h000000, d};
        do begin
            @(posedge ref_clk);
            t++;
            if (t > 20) timed_out();
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        bus(a, 1'b1, 4'hF, d);
    endtask : wr

    task automatic rdc(input logic [9:0] a, input logic [7:0] e);
        bus(a, 1'b0, 4'hF, 8'h00);
        chk_reg("read back", e, rd);
    endtask : rdc

    // Runs to the next match pulse; serial tick must mirror it
    task automatic wait_match(output int cyc, output logic [7:0] top);
        cyc = 0;
        top = 8'h00;
        do begin
            @(posedge ref_clk);
            cyc++;
            if (pwm_base_count > top) top = pwm_base_count;
            chk_bit("serial tick", pwm_base_match, sync_serial_tick);
            if (cyc > 2000) timed_out();
        end while (pwm_base_match !== 1'b1);
    endtask : wait_match

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        num_errors = 0;
        n_compared = 0;
        sys_rst = 1'b1;
        avs_address = 10'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'h0;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        // Table of register cases
        foreach (ROWS[i]) begin
            if (ROWS[i].w) bus(ROWS[i].a, 1'b1, ROWS[i].be, ROWS[i].d);
            rdc(ROWS[i].a, ROWS[i].e);
        end
        // Wrap point and spacing for every prescale code
        wr(A_PER, 8'h03);
        for (k = 0; k < 4; k++) begin
            wr(A_CTL, {5'h00, 1'b1, k[1:0]});
            wait_match(n, tp);
            chk_reg("count at match", 8'h00, pwm_base_count);
            wait_match(n, tp);
            chk_num("spacing", (k == 0) ? 16 : (k == 1) ? 64 : 256, n);
            chk_reg("top count", 8'h03, tp);
        end
        // Postscaler ratios, sticky flag and masking
        wr(A_PER, 8'h01);
        wr(A_ENA, 8'h02);
        for (k = 0; k < 3; k++) begin
            m = (k == 0) ? 0 : (k == 1) ? 2 : 15;
            wr(A_CTL, 8'h00);
            wr(A_FLG, 8'h00);
            wr(A_CTL, {1'b0, m[3:0], 3'b100});
            n = 0;
            for (int c = 0; c < 1000 && irq !== 1'b1; c++) begin
                @(posedge ref_clk);
                if (pwm_base_match === 1'b1) n++;
            end
            if (irq !== 1'b1) timed_out();
            repeat (2) begin
                @(posedge ref_clk);
                if (pwm_base_match === 1'b1) n++;
            end
            chk_num("matches per flag", m + 1, n);
            wr(A_CTL, {1'b0, m[3:0], 3'b000});
            chk_bit("irq held", 1'b1, irq);
            rdc(A_FLG, 8'h02);
            @(posedge ref_clk);
            chk_bit("irq after clear", 1'b0, irq);
            rdc(A_FLG, 8'h00);
        end
        wr(A_FLG, 8'h02);
        @(posedge ref_clk);
        chk_bit("irq enabled", 1'b1, irq);
        wr(A_ENA, 8'h00);
        @(posedge ref_clk);
        chk_bit("irq masked", 1'b0, irq);
        rdc(A_FLG, 8'h02);
        rdc(A_FLG, 8'h00);
        // Stopped timer holds; control write keeps the count
        wr(A_CNT, 8'h42);
        wr(A_CTL, 8'h00);
        rdc(A_CNT, 8'h42);
        repeat (40) @(posedge ref_clk);
        rdc(A_CNT, 8'h42);
        // Count or control write in mid-prescale restarts the scalers
        wr(A_PER, 8'h00);
        wr(A_CNT, 8'h00);
        wr(A_CTL, 8'h06);
        for (k = 0; k < 2; k++) begin
            wait_match(n, tp);
            repeat (30) @(posedge ref_clk);
            wr((k == 0) ? A_CNT : A_CTL, (k == 0) ? 8'h00 : 8'h06);
            wait_match(n, tp);
            chk_bit("scaler restart", 1'b1, n >= 58 && n <= 70);
        end
        // Reset in mid-run returns every register to its reset value
        wr(A_ENA, 8'h02);
        wr(A_CNT, 8'h5A);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        chk_bit("irq after reset", 1'b0, irq);
        for (k = 0; k < 5; k++) begin
            rdc(ROWS[k].a, ROWS[k].e);
        end
        give_verdict();
    end

endmodule : tb_period_timer
`default_nettype wire
